// file: logic/icw_pkg.sv
// package: constants and types for the i2c configuration write target
package icw_pkg;

    // ------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------
    localparam logic [2:0] OP_WRITE      = 3'h3;
    localparam logic [2:0] OP_READ       = 3'h4;
    localparam int         OP_MSB        = 2;
    localparam int         OP_LSB        = 0;
    localparam int         PSEL_HI_BIT   = 0;
    localparam int         PSEL_LO_BIT   = 7;
    localparam int         BE_MSB        = 5;
    localparam int         BE_LSB        = 2;
    localparam int         AHI_MSB       = 1;
    localparam int         AHI_LSB       = 0;
    localparam logic [1:0] PORT_BAD      = 2'h3;
    localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;

    // ------------------------------------------------------------
    // address byte and frame layout
    // ------------------------------------------------------------
    localparam logic [3:0] TADDR_FIXED   = 4'h7;
    localparam logic       DIR_WRITE     = 1'b0;
    localparam int         NUM_CMD       = 4;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [1:0] IDX_LAST      = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] STRAP_RST     = 3'h0;
    localparam logic [7:0] WRCNT_RST     = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_CMD  = 4'h4,
        ST_DATA = 4'h8
    } icw_state_t;

    typedef struct packed {
        logic [7:0]  c0;
        logic [7:0]  c1;
        logic [7:0]  c2;
        logic [7:0]  c3;
        logic [31:0] data;
    } icw_pay_t;

    typedef struct packed {
        logic [1:0]  port;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] data;
    } icw_wr_t;

endpackage : icw_pkg

// file: logic/icw_sync.sv
// two-flop synchroniser for a level or a toggle
module icw_sync #(
    parameter int WIDTH = 1
) (
    input  logic             clk,
    input  logic             rst,
    input  logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("icw_sync: WIDTH must be at least 1");
    end

    // meta_r feeds sync_r only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule : icw_sync

// file: logic/icw_dec.sv
// command decoder: fields and validity of a received write frame
module icw_dec (
    input  icw_pkg::icw_pay_t pay,
    output icw_pkg::icw_wr_t  wr,
    output logic              is_write,
    output logic              invalid
);
    import icw_pkg::*;

    logic [2:0] op;
    logic [1:0] port;

    assign op   = pay.c0[OP_MSB:OP_LSB];                     // R08
    assign port = {pay.c1[PSEL_HI_BIT], pay.c2[PSEL_LO_BIT]}; // R09

    assign wr.port = port;
    assign wr.be   = pay.c2[BE_MSB:BE_LSB];                  // R10
    assign wr.addr = {pay.c2[AHI_MSB:AHI_LSB], pay.c3, ADDR_LOW_ZERO}; // R12
    assign wr.data = pay.data;

    // read opcode is legal but nothing acts on it
    assign invalid  = ((op != OP_WRITE) && (op != OP_READ)) || (port == PORT_BAD); // R16
    assign is_write = (op == OP_WRITE) && !invalid;          // R03

endmodule : icw_dec

// file: logic/icw_top.sv
// top: i2c target that receives configuration register writes
// Functional notes
// R01 - frame is address byte, four command bytes, data bytes, each acknowledged
// R02 - controller brackets each frame with start and stop
// R03 - an invalid command leaves the addressed register untouched
// R04 - first data byte lands in bits 31:24, then bytes 2, 1, 0
// R05 - controller always sends four data bytes whatever the enables
// R06 - after fourth data byte controller sends stop or repeated start
// R07 - any data byte beyond the fourth gets no acknowledge
// R08 - command byte 0 bits 2:0 are opcode, 011b means write
// R09 - port select is cmd1 bit 0 over cmd2 bit 7
// R10 - cmd2 bits 5:2 are byte enables, bit 2 for bits 7:0
// R11 - only enabled bytes change, disabled bytes keep their contents
// R12 - dword address is cmd2 bits 1:0, cmd3, then two zero bits
// R13 - address byte is seven address bits over a direction bit, zero writes
// R14 - target address is 0111 over three strap pins
// R15 - write is committed only after all four data bytes are acknowledged
// R16 - port select 3 or unknown opcode is invalid, nothing changes
module icw_top (
    input  logic              REF_CLK,
    input  logic              RESET,
    input  logic              SCL,
    input  logic              SDA_I,
    output logic              SDA_O,
    output logic              SDA_OE,
    input  logic [2:0]        ADDR_STRAP,
    input  logic              ERR_CLR,
    output logic              CFG_WR_EN,
    output icw_pkg::icw_wr_t  CFG_WR,
    output logic              CMD_ERR,
    output logic [7:0]        WR_COUNT,
    output logic              LINK_BUSY
);
    import icw_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic       lrst;
    logic [2:0] strap_l;
    logic       sda_hi_r;
    logic [7:0] shift_r;
    icw_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] idx_r;
    logic       ack_r;
    logic [7:0] cmd_r [NUM_CMD];
    logic [31:0] data_r;
    icw_pay_t   pay_r;
    logic       commit_tg_r;
    logic       start_det;
    logic       byte_end;
    logic       slot_end;
    logic       addr_hit;
    logic       last_data;

    logic [2:0] strap_s;
    logic [2:0] strap_r;
    logic       tg_s;
    logic       tg_d_r;
    logic       commit_evt;
    logic       busy_s;
    icw_wr_t    dec_wr;
    logic       dec_write;
    logic       dec_invalid;
    logic       sda_o_r;
    logic       wr_en_r;
    icw_wr_t    wr_r;
    logic       err_r;
    logic [7:0] wr_cnt_r;
    logic       busy_r;

    // ------------------------------------------------------------
    // link domain: reset and strap crossing
    // ------------------------------------------------------------
    // the link clock may be still during reset, so the
    // bench must clock scl a few times while reset is held
    icw_sync #(
        .WIDTH (1)
    ) u_lrst (
        .clk (SCL),
        .rst (1'b0),
        .d   (RESET),
        .q   (lrst)
    );

    icw_sync #(
        .WIDTH (3)
    ) u_lstrap (
        .clk (SCL),
        .rst (lrst),
        .d   (strap_r),
        .q   (strap_l)
    );

    // ------------------------------------------------------------
    // link domain: bit sampling on the rising edge
    // ------------------------------------------------------------
    always_ff @(posedge SCL) begin
        if (lrst) begin
            sda_hi_r <= 1'b1;
            shift_r  <= 8'h00;
        end else begin
            sda_hi_r <= SDA_I;
            shift_r  <= {shift_r[6:0], SDA_I};
        end
    end

    // ------------------------------------------------------------
    // link domain: frame decode on the falling edge
    // ------------------------------------------------------------
    // a start is seen at the falling edge that follows it: sda
    // high at the rise and low at the fall; when idle, any low
    // fall counts, since a stop then start leaves no high sample
    assign start_det = (state_r == ST_IDLE) ? ~SDA_I : (sda_hi_r & ~SDA_I); // R02
    assign byte_end  = (state_r != ST_IDLE) && (bit_cnt_r == BIT_LAST);
    assign slot_end  = (state_r != ST_IDLE) && (bit_cnt_r == BIT_ACK);
    assign addr_hit  = (shift_r[7:1] == {TADDR_FIXED, strap_l})             // R14
                    && (shift_r[0] == DIR_WRITE);                          // R13
    assign last_data = (state_r == ST_DATA) && (idx_r == IDX_LAST);

    always_ff @(negedge SCL) begin
        if (lrst) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            idx_r     <= 2'h0;
        end else if (start_det) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            idx_r     <= 2'h0;
        end else if (slot_end) begin
            bit_cnt_r <= 4'h0;
            case (state_r)
                ST_ADDR: begin
                    state_r <= ack_r ? ST_CMD : ST_IDLE;                  // R01
                end
                ST_CMD: begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == IDX_LAST) begin
                        state_r <= ST_DATA;                               // R01
                    end
                end
                ST_DATA: begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == IDX_LAST) begin
                        state_r <= ST_IDLE;                               // R06
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end else if (state_r != ST_IDLE) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // link domain: acknowledge drive
    // ------------------------------------------------------------
    // driven from the fall after bit 0 to the fall after the slot;
    // idle never drives, so extra bytes see a released line
    always_ff @(negedge SCL) begin
        if (lrst || start_det) begin
            ack_r <= 1'b0;
        end else if (byte_end) begin
            case (state_r)
                ST_ADDR: begin
                    ack_r <= addr_hit;                                    // R13
                end
                ST_CMD, ST_DATA: begin
                    ack_r <= 1'b1;                                        // R01
                end
                default: begin
                    ack_r <= 1'b0;                                        // R07
                end
            endcase
        end else begin
            ack_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // link domain: byte capture
    // ------------------------------------------------------------
    always_ff @(negedge SCL) begin
        if (lrst) begin
            data_r <= 32'h0000_0000;
        end else if (byte_end && (state_r == ST_DATA)) begin
            data_r <= {data_r[23:0], shift_r};                           // R04
        end
    end

    for (genvar i = 0; i < NUM_CMD; i++) begin : g_cmd
        always_ff @(negedge SCL) begin
            if (lrst) begin
                cmd_r[i] <= 8'h00;
            end else if (byte_end && (state_r == ST_CMD) && (idx_r == 2'(i))) begin
                cmd_r[i] <= shift_r;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: commit handoff
    // ------------------------------------------------------------
    // pay_r holds still until the next commit, many scl periods
    // later, so the core may read it once the toggle arrives
    always_ff @(negedge SCL) begin
        if (lrst) begin
            pay_r       <= '{8'h00, 8'h00, 8'h00, 8'h00, 32'h0000_0000};
            commit_tg_r <= 1'b0;
        end else if (slot_end && last_data && !start_det) begin
            pay_r       <= '{cmd_r[0], cmd_r[1], cmd_r[2], cmd_r[3], data_r}; // R15
            commit_tg_r <= ~commit_tg_r;                                 // R05
        end
    end

    assign SDA_OE = ack_r;

    // ------------------------------------------------------------
    // core domain: strap capture
    // ------------------------------------------------------------
    icw_sync #(
        .WIDTH (3)
    ) u_strap (
        .clk (REF_CLK),
        .rst (1'b0),
        .d   (ADDR_STRAP),
        .q   (strap_s)
    );

    // straps are caught while reset is held and kept afterwards
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            strap_r <= strap_s;                                          // R14
        end
    end

    // ------------------------------------------------------------
    // core domain: commit and busy crossing
    // ------------------------------------------------------------
    icw_sync #(
        .WIDTH (1)
    ) u_commit (
        .clk (REF_CLK),
        .rst (RESET),
        .d   (commit_tg_r),
        .q   (tg_s)
    );

    icw_sync #(
        .WIDTH (1)
    ) u_busy (
        .clk (REF_CLK),
        .rst (RESET),
        .d   (state_r != ST_IDLE),
        .q   (busy_s)
    );

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            tg_d_r <= 1'b0;
        end else begin
            tg_d_r <= tg_s;
        end
    end

    assign commit_evt = tg_s ^ tg_d_r;

    icw_dec u_dec (
        .pay      (pay_r),
        .wr       (dec_wr),
        .is_write (dec_write),
        .invalid  (dec_invalid)
    );

    // ------------------------------------------------------------
    // core domain: write strobe
    // ------------------------------------------------------------
    // an all-disabled write changes nothing, so no strobe is sent
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wr_en_r <= 1'b0;
        end else begin
            wr_en_r <= commit_evt && dec_write && (dec_wr.be != 4'h0);   // R11
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wr_r <= '{2'h0, 12'h000, 4'h0, 32'h0000_0000};
        end else if (commit_evt && dec_write) begin
            wr_r <= dec_wr;                                              // R03
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wr_cnt_r <= WRCNT_RST;
        end else if (commit_evt && dec_write && (dec_wr.be != 4'h0)) begin
            wr_cnt_r <= wr_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // core domain: status
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            err_r <= 1'b0;
        end else if (commit_evt && dec_invalid) begin
            err_r <= 1'b1;                                               // R16
        end else if (ERR_CLR) begin
            err_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            busy_r  <= 1'b0;
            sda_o_r <= 1'b0;
        end else begin
            busy_r  <= busy_s;
            sda_o_r <= 1'b0;
        end
    end

    assign SDA_O     = sda_o_r;
    assign CFG_WR_EN = wr_en_r;
    assign CFG_WR    = wr_r;
    assign CMD_ERR   = err_r;
    assign WR_COUNT  = wr_cnt_r;
    assign LINK_BUSY = busy_r;

endmodule : icw_top

// file: bench/icw_properties.sv
// checker: port-level properties of the i2c configuration write target
module icw_properties
    import icw_pkg::*;
(
    input logic       REF_CLK,
    input logic       RESET,
    input logic       SCL,
    input logic       SDA_O,
    input logic       SDA_OE,
    input logic       ERR_CLR,
    input logic       CFG_WR_EN,
    input icw_wr_t    CFG_WR,
    input logic       CMD_ERR,
    input logic [7:0] WR_COUNT
);
    // ------------------------------------------------------------
    // link side
    // ------------------------------------------------------------
    a_ack_one_slot: assert property (@(negedge SCL) disable iff (RESET)
        SDA_OE |=> !SDA_OE) else $error("acknowledge held past one slot");
    a_sda_open_drain: assert property (@(posedge REF_CLK) disable iff (RESET)
        SDA_OE |-> SDA_O == 1'b0) else $error("data line driven high");
    // ------------------------------------------------------------
    // commit port
    // ------------------------------------------------------------
    a_strobe_single: assert property (@(posedge REF_CLK) disable iff (RESET)
        CFG_WR_EN |=> !CFG_WR_EN) else $error("write strobe longer than one cycle");
    a_count_steps: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(CFG_WR_EN) |-> WR_COUNT == $past(WR_COUNT) + 8'h01)
        else $error("write count not one up at strobe");
    a_count_cause: assert property (@(posedge REF_CLK) disable iff (RESET)
        $changed(WR_COUNT) |-> CFG_WR_EN) else $error("write count moved without strobe");
    a_addr_low_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        CFG_WR_EN |-> CFG_WR.addr[1:0] == ADDR_LOW_ZERO) else $error("address low bits set");
    a_port_legal: assert property (@(posedge REF_CLK) disable iff (RESET)
        CFG_WR_EN |-> CFG_WR.port != PORT_BAD) else $error("strobe with port three");
    a_be_nonzero: assert property (@(posedge REF_CLK) disable iff (RESET)
        CFG_WR_EN |-> CFG_WR.be != 4'h0) else $error("strobe with no byte enabled");
    a_err_sticky: assert property (@(posedge REF_CLK) disable iff (RESET)
        CMD_ERR && !ERR_CLR |=> CMD_ERR) else $error("error flag dropped without clear");
    a_err_no_write: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(CMD_ERR) |-> !CFG_WR_EN) else $error("invalid frame committed");
endmodule : icw_properties

// file: bench/icw_host.sv
// partner model: i2c controller that issues write frames
module icw_host (
    output logic scl,
    output logic sda_rel,
    input  wire  sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 15;

    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // clock only runs here; stands high between frames
    task automatic idle(input int n);
        repeat (n) begin
            #HALF scl = 1'b0;
            #HALF scl = 1'b1;
        end
    endtask : idle

    // data moves 2 ns after the fall so the target never races it
    task automatic start(input logic rep);
        if (rep) begin
            #2 sda_rel = 1'b1;
            #(HALF - 2) scl = 1'b1;
        end
        #HALF sda_rel = 1'b0;
        #HALF scl = 1'b0;
    endtask : start

    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #2 sda_rel = b[i];
            #(HALF - 2) scl = 1'b1;
            #HALF scl = 1'b0;
        end
        #2 sda_rel = 1'b1;
        #(HALF - 2) scl = 1'b1;
        ack = (sda === 1'b0);
        #HALF scl = 1'b0;
    endtask : wbyte

    task automatic stop();
        #2 sda_rel = 1'b0;
        #(HALF - 2) scl = 1'b1;
        #HALF sda_rel = 1'b1;
        #HALF;
    endtask : stop
endmodule : icw_host

// file: bench/icw_top_bench.sv
// testbench: write frames through the i2c target, check the commit port
module icw_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import icw_pkg::*;

    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] dat;
        logic        ok;
        logic        err;
        icw_wr_t     wr;
    } icw_row_t;

    localparam logic [7:0] ADR = 8'h7A;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       err_clr = 1'b0;
    logic [2:0] strap = 3'h5;
    logic       scl;
    logic       sda_rel;
    wire        sda;
    logic       sda_o;
    logic       sda_oe;
    logic       cfg_wr_en;
    icw_wr_t    cfg_wr;
    logic       cmd_err;
    logic [7:0] wr_count;
    logic       link_busy;
    icw_wr_t    last_wr;
    int         strobes = 0;
    int         failures = 0;
    int         cmp_count = 0;
    icw_row_t   rows[5];

    // pull-up wins unless a party pulls low
    assign sda = sda_rel & (sda_oe !== 1'b1);
    always #5 ref_clk = ~ref_clk;

    icw_top uut (.REF_CLK(ref_clk), .RESET(reset), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .ADDR_STRAP(strap), .ERR_CLR(err_clr), .CFG_WR_EN(cfg_wr_en),
        .CFG_WR(cfg_wr), .CMD_ERR(cmd_err), .WR_COUNT(wr_count), .LINK_BUSY(link_busy));
    icw_host host (.scl(scl), .sda_rel(sda_rel), .sda(sda));

    always @(posedge ref_clk) begin
        if (cfg_wr_en === 1'b1) begin
            strobes <= strobes + 1;
            last_wr <= cfg_wr;
        end
    end

    // ------------------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_wr(input icw_wr_t got, input icw_wr_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_wr

    task automatic frame(input logic [7:0] adr, input logic [31:0] cmd, input logic [31:0] dat,
                         input int n, input logic rep, output logic [9:0] a);
        logic [79:0] bytes;
        logic        k;
        bytes = {adr, cmd, dat, 8'hFF};
        a = '0;
        host.start(rep);
        for (int i = 0; i < n; i++) begin
            host.wbyte(bytes[79-8*i -: 8], k);
            a[i] = k;
        end
    endtask : frame

    task automatic run(input icw_row_t r);
        int         s0;
        logic [7:0] n0;
        logic [9:0] a;
        s0 = strobes;
        n0 = wr_count;
        frame(ADR, r.cmd, r.dat, 9, 1'b0, a);
        host.stop();
        repeat (8) @(posedge ref_clk);
        chk_val(32'(a), 32'h1FF);
        chk_val(32'(strobes - s0), 32'(r.ok));
        chk_val(32'(wr_count), 32'(n0 + 8'(r.ok)));
        chk_val(32'(cmd_err), 32'(r.err));
        chk_val(32'(link_busy), 32'h0);
        if (r.ok) begin
            chk_wr(last_wr, r.wr);
        end
        if (r.err) begin
            @(posedge ref_clk) err_clr <= 1'b1;
            @(posedge ref_clk) err_clr <= 1'b0;
            repeat (2) @(negedge ref_clk);
            chk_val(32'(cmd_err), 32'h0);
        end
    endtask : run

    task automatic conclude();
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        icw_row_t   r;
        logic [9:0] a;
        int         s0;
        rows[0] = '{32'h03003C2D, 32'h12345678, 1'b1, 1'b0, '{2'h0, 12'h0B4, 4'hF, 32'h12345678}};
        rows[1] = '{32'h030084FF, 32'hA1B2C3D4, 1'b1, 1'b0, '{2'h1, 12'h3FC, 4'h1, 32'hA1B2C3D4}};
        rows[2] = '{32'h03012301, 32'h0F1E2D3C, 1'b1, 1'b0, '{2'h2, 12'hC04, 4'h8, 32'h0F1E2D3C}};
        rows[3] = '{32'hFB001800, 32'h99887766, 1'b1, 1'b0, '{2'h0, 12'h000, 4'h6, 32'h99887766}};
        rows[4] = '{32'h0301BC2D, 32'h55555555, 1'b0, 1'b1, '0};
        fork
            repeat (12) @(posedge ref_clk);
            host.idle(3);
        join
        chk_val(32'({cfg_wr_en, cmd_err, link_busy, sda_oe, sda_o, wr_count}), 32'h0);
        chk_wr(cfg_wr, '0);
        reset <= 1'b0;
        host.idle(3);
        foreach (rows[i]) begin
            run(rows[i]);
        end
        // every opcode; only write commits, read is quietly ignored
        for (int op = 0; op < 8; op++) begin
            r = '{{5'h00, 3'(op), 24'h003C2D}, 32'h5A5AC3C3, 1'(op == 3),
                  1'(op != 3 && op != 4), '{2'h0, 12'h0B4, 4'hF, 32'h5A5AC3C3}};
            run(r);
        end
        run('{32'h0300002D, 32'h77777777, 1'b0, 1'b0, '0});
        frame(8'h78, 32'h0, 32'h0, 1, 1'b0, a);
        host.stop();
        chk_val(32'(a), 32'h0);
        frame(8'h7B, 32'h0, 32'h0, 1, 1'b0, a);
        host.stop();
        chk_val(32'(a), 32'h0);
        s0 = strobes;
        frame(ADR, 32'h03003C2D, 32'hCAFE0001, 10, 1'b0, a);
        host.stop();
        repeat (8) @(posedge ref_clk);
        chk_val(32'(a), 32'h1FF);
        chk_val(32'(strobes - s0), 32'h1);
        // full frame, then one cut short, then one more, joined by repeated starts
        s0 = strobes;
        frame(ADR, 32'h03003C2D, 32'hAAAA0001, 9, 1'b0, a);
        frame(ADR, 32'h03003C2D, 32'hBBBB0002, 7, 1'b1, a);
        repeat (4) @(posedge ref_clk);
        chk_val(32'(link_busy), 32'h1);
        frame(ADR, 32'h030084FF, 32'hCCCC0003, 9, 1'b1, a);
        host.stop();
        repeat (8) @(posedge ref_clk);
        chk_val(32'(a), 32'h1FF);
        chk_val(32'(strobes - s0), 32'h2);
        chk_wr(last_wr, '{2'h1, 12'h3FC, 4'h1, 32'hCCCC0003});
        conclude();
    end

    initial begin
        #400us;
        failures++;
        conclude();
    end
endmodule : icw_top_bench

bind icw_top icw_properties u_props (.REF_CLK(REF_CLK), .RESET(RESET), .SCL(SCL),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ERR_CLR(ERR_CLR), .CFG_WR_EN(CFG_WR_EN),
    .CFG_WR(CFG_WR), .CMD_ERR(CMD_ERR), .WR_COUNT(WR_COUNT));
